// file: prlc_defs.vh
// Constants of the transceiver housekeeping block: register indices, fields,
// reset values and timing counts. Assumes a 10 MHz system clock.
// What this block does
// - MII mode: reference input is 25 MHz.
// - RMII mode: 50 MHz reference is primary clock.
// - Mode one: indicator on while link good.
// - Mode two: on when linked, blink on activity.
// - Reset pin low reinitialises all but bus, event history and sync registers.
// - Reset pin low one microsecond starts reset.
// - Every hardware reset retakes strap options.
// - Shared pin powers down until software selects interrupt.
// - Low shared pin in power-down function sleeps device.
// - Interrupt function pulls shared pin low, open-drain.
// - Software may switch internal regulator off.
// - Indicator mode defaults from strap, register selects either.
// - Regulator control bit 15 powers regulator down.
// - Mode strap high selects RMII, else MII.
// - Straps captured while reset is active.
`ifndef PRLC_DEFS_VH
`define PRLC_DEFS_VH

// Register indices; the byte address is four times the index.
`define PRLC_IDX_PHY_CONTROL   8'h19
`define PRLC_IDX_IRQ_STATUS    8'h20
`define PRLC_IDX_IRQ_MASK      8'h21
`define PRLC_IDX_REG_CONTROL   8'hd0

// Fields of phy_control.
`define PRLC_PHY_CONTROL_PIN_IRQ     0
`define PRLC_PHY_CONTROL_IND_MODE2   5
`define PRLC_PHY_CONTROL_RMII        8
`define PRLC_PHY_CONTROL_RST         16'h0000

// Fields of regulator_control.
`define PRLC_REGULATOR_CONTROL_OFF          15
`define PRLC_REGULATOR_CONTROL_RST          16'h0000

// Interrupt status and mask bits.
`define PRLC_IRQ_W             3
`define PRLC_IRQ_LINK_CHG      0
`define PRLC_IRQ_ACT_START     1
`define PRLC_IRQ_RST_DONE      2
`define PRLC_IRQ_RST           3'h0

// Reference clock figures in MHz for each interface mode.
`define PRLC_REF_MII_MHZ       8'h19
`define PRLC_REF_RMII_MHZ      8'h32

// Timing.
`define PRLC_CLK_PERIOD_NS     100
`define PRLC_RST_MIN_NS        1000
`define PRLC_RST_MIN_CYC       ((`PRLC_RST_MIN_NS + `PRLC_CLK_PERIOD_NS - 1) / `PRLC_CLK_PERIOD_NS)
`define PRLC_BLINK_HALF_NS     50000000
`define PRLC_BLINK_HALF_CYC    (`PRLC_BLINK_HALF_NS / `PRLC_CLK_PERIOD_NS)

`endif

// file: prlc_blink_gen.v
// Square-wave generator for the activity blink of the status indicator.
// Assumes one clock domain; the count runs only while enabled.
`timescale 1ns/1ps
module prlc_blink_gen #(
  parameter HALF_CYC = 500000
) (
  input  wire       sys_clk_i,
  input  wire       rst_i,
  input  wire       en_i,
  output wire       phase_o
);
  reg  [23:0] cnt_q;
  reg         phase_q;

  always @(posedge sys_clk_i) begin
    if (rst_i || !en_i) begin
      cnt_q   <= 24'h000000;
      phase_q <= 1'b0;
    end else if (cnt_q >= HALF_CYC[23:0] - 24'h000001) begin
      cnt_q   <= 24'h000000;
      phase_q <= ~phase_q;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

  assign phase_o = phase_q;
endmodule // prlc_blink_gen

// file: prlc_top.v
// Housekeeping logic of a 10/100 transceiver: reset pin, straps, status
// indicator, shared interrupt/power-down pin and regulator control.
// Registers are reached over a classic Wishbone slave on sys_clk_i.
// Pins and straps come from outside and are synchronised here.
// Straps are sampled on every clock while a reset is active.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "prlc_defs.vh"
module prlc_top #(
  parameter BLINK_HALF_CYC = `PRLC_BLINK_HALF_CYC
) (
  input  wire        sys_clk_i,
  input  wire        srst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        hw_reset_n_i,
  input  wire        mii_mode_strap_i,
  input  wire        indicator_style_strap_i,
  input  wire        link_good_i,
  input  wire        tx_active_i,
  input  wire        rx_active_i,
  input  wire        irq_or_sleep_pin_i,
  output wire        irq_or_sleep_pin_o,
  output wire        irq_or_sleep_pin_oe_o,
  output wire        link_indicator_o,
  output wire        power_down_o,
  output wire        regulator_off_o,
  output wire        rmii_mode_o,
  output wire [7:0]  ref_clock_mhz_o,
  output wire        core_reset_o,
  output wire        irq_o
);
  // Synchronisers for the pins. The reset pin and the shared pin rest at
  // their pulled-up level while srst_i is high, so no false low is seen.
  reg  [1:0]  rstn_sync_q;
  reg  [1:0]  mode_strap_sync_q;
  reg  [1:0]  ind_strap_sync_q;
  reg  [1:0]  pin_sync_q;

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      rstn_sync_q <= 2'h3;
      pin_sync_q  <= 2'h3;
    end else begin
      rstn_sync_q <= {rstn_sync_q[0], hw_reset_n_i};
      pin_sync_q  <= {pin_sync_q[0], irq_or_sleep_pin_i};
    end
  end

  // The strap synchronisers run through srst_i as well, so the levels taken
  // while any reset is active are those of the pins, not a fixed default.
  always @(posedge sys_clk_i) begin
    mode_strap_sync_q <= {mode_strap_sync_q[0], mii_mode_strap_i};
    ind_strap_sync_q  <= {ind_strap_sync_q[0], indicator_style_strap_i};
  end

  wire rstn_s      = rstn_sync_q[1];
  wire mode_strap  = mode_strap_sync_q[1];
  wire ind_strap   = ind_strap_sync_q[1];
  wire pin_level_s = pin_sync_q[1];

  // The low time is counted on the synchronised level, so a pulse shorter
  // than the minimum leaves the core alone. The reset then holds until the
  // pin is seen high again.
  // qualify reset pulse.
  reg  [3:0]  low_cnt_q;
  reg         pin_rst_q;
  wire        rst_cnt_full = (low_cnt_q >= `PRLC_RST_MIN_CYC);

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      low_cnt_q <= 4'h0;
      pin_rst_q <= 1'b0;
    end else if (rstn_s) begin
      low_cnt_q <= 4'h0;
      pin_rst_q <= 1'b0;
    end else begin
      if (!rst_cnt_full) begin
        low_cnt_q <= low_cnt_q + 4'h1;
      end
      pin_rst_q <= pin_rst_q | ((low_cnt_q + 4'h1) >= `PRLC_RST_MIN_CYC);
    end
  end

  // The bus acknowledge is left out, so a transfer in flight still ends.
  // pin reset reaches all registers but the bus, event history and synchronisers.
  wire int_rst = srst_i | pin_rst_q;

  reg         rmii_q;

  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      rmii_q <= mode_strap;
    end
  end

  // Wishbone slave: one wait state, ack a single cycle. A request is taken
  // only while ack is low, so a master that still holds cyc and stb in the
  // ack cycle is not answered twice.
  reg         ack_q;
  reg  [31:0] rdat_q;
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire [7:0]  wb_idx   = wb_adr_i[9:2];
  wire        wb_wr    = wb_req & wb_we_i;
  wire        wr_lo    = wb_wr & wb_sel_i[0];
  wire        wr_hi    = wb_wr & wb_sel_i[1];

  reg  [15:0] phy_control_q;
  reg  [15:0] regulator_control_q;
  reg  [`PRLC_IRQ_W-1:0] irq_stat_q;
  reg  [`PRLC_IRQ_W-1:0] irq_mask_q;
  reg         rst_done_q;
  reg         link_prev_q;
  reg         act_prev_q;

  // Events: a link change, the start of activity, and the first cycle after
  // any reset has ended.
  wire        act_now  = tx_active_i | rx_active_i;
  wire [`PRLC_IRQ_W-1:0] irq_set;
  assign irq_set[`PRLC_IRQ_LINK_CHG]  = link_good_i ^ link_prev_q;
  assign irq_set[`PRLC_IRQ_ACT_START] = act_now & ~act_prev_q;
  assign irq_set[`PRLC_IRQ_RST_DONE]  = rst_done_q;

  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      // default from strap, pulled-up strap gives mode one.
      phy_control_q     <= `PRLC_PHY_CONTROL_RST;
      phy_control_q[`PRLC_PHY_CONTROL_IND_MODE2] <= ~ind_strap;
      regulator_control_q      <= `PRLC_REGULATOR_CONTROL_RST;
      irq_mask_q  <= `PRLC_IRQ_RST;
      rst_done_q  <= 1'b1;
    end else begin
      rst_done_q <= 1'b0;
      if (wr_lo && wb_idx == `PRLC_IDX_PHY_CONTROL) begin
        phy_control_q[`PRLC_PHY_CONTROL_PIN_IRQ]   <= wb_dat_i[`PRLC_PHY_CONTROL_PIN_IRQ];
        phy_control_q[`PRLC_PHY_CONTROL_IND_MODE2] <= wb_dat_i[`PRLC_PHY_CONTROL_IND_MODE2];
      end
      if (wr_hi && wb_idx == `PRLC_IDX_REG_CONTROL) begin
        regulator_control_q[`PRLC_REGULATOR_CONTROL_OFF] <= wb_dat_i[`PRLC_REGULATOR_CONTROL_OFF];
      end
      if (wr_lo && wb_idx == `PRLC_IDX_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[`PRLC_IRQ_W-1:0];
      end
    end
  end

  // Status bits: set wins over a write-one clear in the same cycle.
  wire [`PRLC_IRQ_W-1:0] irq_clr =
    (wr_lo && wb_idx == `PRLC_IDX_IRQ_STATUS) ? wb_dat_i[`PRLC_IRQ_W-1:0]
                                               : {`PRLC_IRQ_W{1'b0}};

  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      irq_stat_q <= `PRLC_IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // Event history. It follows the inputs through a pin reset as well, so a
  // level already present when the reset ends does not count as an edge.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      link_prev_q <= 1'b0;
      act_prev_q  <= 1'b0;
    end else begin
      link_prev_q <= link_good_i;
      act_prev_q  <= act_now;
    end
  end

  // Read path and acknowledge; unmapped indices read as zero. Read data is
  // loaded in the taken cycle and stands until the next read.
  reg  [31:0] rdat_d;

  always @* begin
    rdat_d = 32'h00000000;
    case (wb_idx)
      `PRLC_IDX_PHY_CONTROL: begin
        rdat_d[15:0] = phy_control_q;
        rdat_d[`PRLC_PHY_CONTROL_RMII] = rmii_q;
      end
      `PRLC_IDX_REG_CONTROL: rdat_d[15:0] = regulator_control_q;
      `PRLC_IDX_IRQ_STATUS:  rdat_d[`PRLC_IRQ_W-1:0] = irq_stat_q;
      `PRLC_IDX_IRQ_MASK:    rdat_d[`PRLC_IRQ_W-1:0] = irq_mask_q;
      default:               rdat_d = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        rdat_q <= rdat_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Status indicator.
  wire        mode2      = phy_control_q[`PRLC_PHY_CONTROL_IND_MODE2];
  wire        blink_ph;
  reg         ind_d;
  reg         ind_q;

  prlc_blink_gen #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .sys_clk_i (sys_clk_i),
    .rst_i     (int_rst),
    .en_i      (mode2 & act_now),
    .phase_o   (blink_ph)
  );

  // In mode two activity overrides the link level, so the light blinks
  // even while the link is down; the phase starts at zero, light on.
  always @* begin
    ind_d = link_good_i;
    if (mode2 && act_now) begin
      // on with link, blinking on activity.
      ind_d = ~blink_ph;
    end
  end

  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      ind_q <= 1'b0;
    end else begin
      ind_q <= ind_d;
    end
  end

  assign link_indicator_o = ind_q;

  // Shared pin and power control. The pin is only ever pulled low; when the
  // enable drops, the pull-up on the board brings it back high.
  wire        pin_irq_fn = phy_control_q[`PRLC_PHY_CONTROL_PIN_IRQ];
  wire        irq_pend   = |(irq_stat_q & irq_mask_q);
  reg         pin_oe_d;
  reg         pwrdn_d;
  reg         pin_oe_q;
  reg         pwrdn_q;
  reg         irq_q;

  always @* begin
    pin_oe_d = 1'b0;
    pwrdn_d  = 1'b0;
    if (pin_irq_fn) begin
      pin_oe_d = irq_pend;
    end else begin
      pwrdn_d  = ~pin_level_s;
    end
  end

  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      pin_oe_q <= 1'b0;
      pwrdn_q  <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      irq_q    <= irq_pend;
      pin_oe_q <= pin_oe_d;
      pwrdn_q  <= pwrdn_d;
    end
  end

  assign irq_or_sleep_pin_o    = 1'b0;
  assign irq_or_sleep_pin_oe_o = pin_oe_q;
  assign power_down_o          = pwrdn_q;
  assign irq_o                 = irq_q;

  // Only the request is made here; the supply rail itself is the board's.
  // register switches regulator off.
  assign regulator_off_o = regulator_control_q[`PRLC_REGULATOR_CONTROL_OFF];

  // The block runs on sys_clk_i; the reference rate is reported only.
  // MII uses 25 MHz reference.
  // RMII uses 50 MHz primary reference.
  assign rmii_mode_o     = rmii_q;
  assign ref_clock_mhz_o = rmii_q ? `PRLC_REF_RMII_MHZ : `PRLC_REF_MII_MHZ;
  assign core_reset_o    = int_rst;
endmodule // prlc_top

// file: prlc_board.sv
// Board model at the shared pin: weak pull-up plus a host switch to ground.
// Assumes the design only ever pulls the pin low, while its enable is high.
`timescale 1ns/1ps
module prlc_board (
  input  wire oe_i,
  input  wire pull_low_i,
  output wire pin_o
);
  assign pin_o = !(oe_i || pull_low_i);
endmodule // prlc_board

// file: prlc_properties.sv
// Checker of the housekeeping block, bound to every prlc_top.
// Sees the top-level ports only, all on sys_clk_i.
`timescale 1ns/1ps
module prlc_props (
  input wire       sys_clk_i,
  input wire       srst_i,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire       wb_ack_o,
  input wire       hw_reset_n_i,
  input wire       link_good_i,
  input wire       tx_active_i,
  input wire       rx_active_i,
  input wire       irq_or_sleep_pin_i,
  input wire       irq_or_sleep_pin_o,
  input wire       irq_or_sleep_pin_oe_o,
  input wire       link_indicator_o,
  input wire       power_down_o,
  input wire       regulator_off_o,
  input wire       rmii_mode_o,
  input wire [7:0] ref_clock_mhz_o,
  input wire       core_reset_o,
  input wire       irq_o
);
  reg [4:0] lo_q;
  // Counts raw cycles of a low reset pin.
  always @(posedge sys_clk_i) begin
    if (srst_i || hw_reset_n_i) lo_q <= 5'h0;
    else if (lo_q != 5'h1f) lo_q <= lo_q + 5'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (core_reset_o);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_od; irq_or_sleep_pin_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin drives high");
  property p_ref; ref_clock_mhz_o == (rmii_mode_o ? 8'h32 : 8'h19); endproperty
  a_ref: assert property (p_ref) else $error("bad ref rate");
  property p_reg; $changed(regulator_off_o) |-> wb_ack_o && wb_we_i; endproperty
  a_reg: assert property (p_reg) else $error("regulator moved");
  property p_pd; power_down_o |-> !irq_or_sleep_pin_oe_o; endproperty
  a_pd: assert property (p_pd) else $error("pin both ways");
  property p_pwd; $rose(power_down_o) |-> !$past(irq_or_sleep_pin_i, 3); endproperty
  a_pwd: assert property (p_pwd) else $error("sleep without pin");
  property p_oe; irq_or_sleep_pin_oe_o |-> irq_o; endproperty
  a_oe: assert property (p_oe) else $error("pin held low");
  property p_off; !link_good_i && !tx_active_i && !rx_active_i |=> !link_indicator_o; endproperty
  a_off: assert property (p_off) else $error("led on");
  property p_on; link_good_i && !tx_active_i && !rx_active_i |=> link_indicator_o; endproperty
  a_on: assert property (p_on) else $error("led off");
  property p_rst; disable iff (srst_i) lo_q >= 5'he |-> core_reset_o; endproperty
  a_rst: assert property (p_rst) else $error("no pin reset");
endmodule // prlc_props
bind prlc_top prlc_props u_props (.*);

// file: prlc_top_tb.sv
// Self-checking bench of the housekeeping block over Wishbone and pins.
// Assumes a 10 MHz clock and a blink half period of 4 cycles.
`timescale 1ns/1ps
module prlc_top_tb;
  localparam [31:0] A_PHY = 32'h64, A_STS = 32'h80, A_MSK = 32'h84, A_REG = 32'h340;
  reg         clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg  [3:0]  sel = 4'hf;
  reg  [31:0] adr = 32'h0, wdat = 32'h0, q;
  reg         rst_n = 1'b1, mstrap = 1'b0, istrap = 1'b1;
  reg         link = 1'b0, tx = 1'b0, rx = 1'b0, plow = 1'b0;
  wire [31:0] rdat;
  wire [7:0]  mhz;
  wire        ack, pin, po, oe, led, pd, roff, rmii, crst, irq;
  integer     err_count = 0, total_checks = 0;
  initial forever #50 clk = ~clk;
  prlc_top #(.BLINK_HALF_CYC(4)) DUT (.sys_clk_i(clk), .srst_i(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .hw_reset_n_i(rst_n), .mii_mode_strap_i(mstrap),
    .indicator_style_strap_i(istrap), .link_good_i(link), .tx_active_i(tx),
    .rx_active_i(rx), .irq_or_sleep_pin_i(pin), .irq_or_sleep_pin_o(po),
    .irq_or_sleep_pin_oe_o(oe), .link_indicator_o(led), .power_down_o(pd),
    .regulator_off_o(roff), .rmii_mode_o(rmii), .ref_clock_mhz_o(mhz),
    .core_reset_o(crst), .irq_o(irq));
  prlc_board u_board (.oe_i(oe), .pull_low_i(plow), .pin_o(pin));
  task ck(input [31:0] g, input [31:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task cy(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // A classic single cycle; holds everything until ack is sampled high.
  task wb(input w, input [31:0] a, input [31:0] d);
    integer n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n = n + 1;
    end
    if (n == 20) begin
      err_count = err_count + 1;
      $display("[ERR] %0t no ack", $time);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input [31:0] a, input [31:0] e);
    wb(1'b0, a, 32'h0);
    ck(q, e);
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_init;
    ck({rmii, mhz}, {1'b0, 8'h19});
    rd(A_PHY, 32'h0);
    rd(A_REG, 32'h0);
    rd(32'h3fc, 32'h0);
    wb(1'b1, A_REG, 32'h8000);
    rd(A_REG, 32'h8000);
    ck(roff, 1'b1);
  endtask
  task t_pd;
    plow <= 1'b1;
    cy(5);
    ck(pd, 1'b1);
    plow <= 1'b0;
    cy(5);
    ck(pd, 1'b0);
  endtask
  task t_irq;
    wb(1'b1, A_STS, 32'h7);
    wb(1'b1, A_MSK, 32'h1);
    wb(1'b1, A_PHY, 32'h1);
    tx <= 1'b1;
    cy(4);
    ck({irq, oe}, 2'b00);
    tx <= 1'b0;
    link <= 1'b1;
    cy(4);
    ck({irq, oe, pin, led, pd}, 5'b11010);
    rd(A_STS, 32'h3);
    wb(1'b1, A_STS, 32'h1);
    cy(3);
    ck({irq, oe, pin}, 3'b001);
  endtask
  task t_led;
    integer i, n;
    wb(1'b1, A_PHY, 32'h121);
    rd(A_PHY, 32'h21);
    link <= 1'b0;
    rx <= 1'b1;
    n = 0;
    for (i = 0; i < 24; i = i + 1) begin
      @(posedge clk);
      if (led !== q[0]) n = n + 1;
      q[0] = led;
    end
    ck(n > 3, 1'b1);
    rx <= 1'b0;
    link <= 1'b1;
    cy(3);
    ck(led, 1'b1);
    wb(1'b1, A_STS, 32'h7);
  endtask
  task t_hw;
    mstrap <= 1'b1;
    rst_n <= 1'b0;
    cy(6);
    rst_n <= 1'b1;
    cy(4);
    ck({crst, roff, rmii}, 3'b010);
    rst_n <= 1'b0;
    cy(16);
    ck(crst, 1'b1);
    rst_n <= 1'b1;
    cy(5);
    ck({rmii, roff, mhz}, {2'b10, 8'h32});
    rd(A_PHY, 32'h100);
  endtask
  initial begin
    #3000000;
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    cy(6);
    srst <= 1'b0;
    cy(3);
    t_init;
    t_pd;
    t_irq;
    t_led;
    t_hw;
    test_done;
  end
endmodule // prlc_top_tb
